// [logic/sios_pkg.sv]
// types shared by the safety io signalling block
`default_nettype none
package sios_pkg;
  typedef enum logic [1:0] {
    SIOS_FN_ESTOP   = 2'h0,
    SIOS_FN_SSTOP   = 2'h1,
    SIOS_FN_MOVE    = 2'h2,
    SIOS_FN_REDUCED = 2'h3
  } sios_func_type;
  typedef enum logic [1:0] {
    SIOS_IN_OFF   = 2'h0,
    SIOS_IN_CAT1  = 2'h1,
    SIOS_IN_CAT2  = 2'h2,
    SIOS_IN_ESTOP = 2'h3
  } sios_incfg_type;
  typedef struct packed {
    logic a;
    logic b;
  } sios_pair_type;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } sios_apb_req_type;
endpackage : sios_pkg
`default_nettype wire

// [logic/sios_regs.svh]
// register map, field positions and timing constants for the safety io signalling block
//
// Contract
// [R1] four safety outputs exist and each carries one selected function out of four.
// [R2] every output drives two redundant pins that always carry the same state.
// [R3] an emergency stop output is low while an emergency stop is active and high otherwise.
// [R4] a safety stop output asserts on a configured input stop, a configured input emergency stop, an internal safety function or a hardware fault.
// [R5] the safety stop output may react to category 1 only, category 2 only, or both.
// [R6] the safety stop output is low while a safety stop is active and high otherwise.
// [R7] a movement output is low while the robot moves and high at standstill.
// [R8] a mode output is high while the reduced parameter set is in effect and low otherwise.
// [R9] the block self-tests its configurable safety inputs on its own, with no outside request.
// [R10] after restart the outside party holds a safety input high for at least two seconds on first actuation.
// [R11] after that first long actuation, actuations shorter than one second are accepted.
// [R12] the operator must not use the self-test fault reset to ignore faults arising in operation.
// [R13] self-test pulses can be enabled per output, and the receiver must then detect stuck-high and shorts.
// [R14] an input configured for safety stop reads low as stop and high as no stop, and only once configured.
// [R15] until configuration is loaded after restart, all outputs sit at their active-low safe state.
`ifndef SIOS_REGS_SVH
`define SIOS_REGS_SVH
`define SIOS_OFF_CTRL     12'h000
`define SIOS_OFF_OUTCFG   12'h004
`define SIOS_OFF_INCFG    12'h008
`define SIOS_OFF_PULSE    12'h00C
`define SIOS_OFF_STATE    12'h010
`define SIOS_OFF_STATUS   12'h014
`define SIOS_OFF_CLEAR    12'h018
`define SIOS_OFF_ENABLE   12'h01C
`define SIOS_CTRL_LOADED  0
`define SIOS_CTRL_MOVING  1
`define SIOS_CTRL_REDUCED 2
`define SIOS_CTRL_ESTOP   3
`define SIOS_CTRL_SFUNC   4
`define SIOS_CTRL_HWFAULT 5
`define SIOS_CTRL_TSTCLR  6
`define SIOS_CLK_HZ       40000000
`define SIOS_FIRST_MS     2000
`define SIOS_SHORT_MS     1000
`define SIOS_TEST_US      1000
`define SIOS_PULSE_US     1
`define SIOS_ZERO32       32'h0000_0000
`endif

// [logic/sios_top.sv]
// safety output signalling and input self-test with apb registers
//
// Our own choices: the APB interface to the registers and the register offsets.
`include "sios_regs.svh"
`default_nettype none
module sios_top #(
  parameter int unsigned NUM_IO     = 4,
  parameter int unsigned FIRST_CYC  = `SIOS_CLK_HZ / 1000 * `SIOS_FIRST_MS,
  parameter int unsigned SHORT_CYC  = `SIOS_CLK_HZ / 1000 * `SIOS_SHORT_MS,
  parameter int unsigned TEST_CYC   = `SIOS_CLK_HZ / 1000000 * `SIOS_TEST_US,
  parameter int unsigned PULSE_CYC  = `SIOS_CLK_HZ / 1000000 * `SIOS_PULSE_US
) (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire sios_pkg::sios_apb_req_type apb_req,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire sios_pkg::sios_pair_type    safe_in   [NUM_IO],
  output sios_pkg::sios_pair_type         safe_out  [NUM_IO],
  output logic [NUM_IO-1:0]               test_drive_n,
  output logic                            irq
);
  import sios_pkg::*;
  localparam int CW = 32;

  // =====================================================
  // apb slave
  logic [31:0] ctrl_q, outcfg_q, incfg_q, pulse_q, status_q, enable_q;
  wire acc   = apb_req.psel & apb_req.penable;
  wire wr    = acc & apb_req.pwrite;
  wire hit_c = apb_req.paddr == `SIOS_OFF_CTRL;
  wire hit_o = apb_req.paddr == `SIOS_OFF_OUTCFG;
  wire hit_i = apb_req.paddr == `SIOS_OFF_INCFG;
  wire hit_p = apb_req.paddr == `SIOS_OFF_PULSE;
  wire hit_s = apb_req.paddr == `SIOS_OFF_STATE;
  wire hit_t = apb_req.paddr == `SIOS_OFF_STATUS;
  wire hit_k = apb_req.paddr == `SIOS_OFF_CLEAR;
  wire hit_e = apb_req.paddr == `SIOS_OFF_ENABLE;
  wire hit   = hit_c | hit_o | hit_i | hit_p | hit_s | hit_t | hit_k | hit_e;
  logic [31:0] state_w;
  wire  [31:0] rd_w = hit_c ? ctrl_q : hit_o ? outcfg_q : hit_i ? incfg_q : hit_p ? pulse_q :
                      hit_s ? state_w : hit_t ? status_q : hit_e ? enable_q : `SIOS_ZERO32;
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata <= `SIOS_ZERO32;
    end else if (apb_req.psel & ~apb_req.penable & ~apb_req.pwrite) begin
      prdata <= rd_w;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q   <= `SIOS_ZERO32;
      outcfg_q <= `SIOS_ZERO32;
      incfg_q  <= `SIOS_ZERO32;
      pulse_q  <= `SIOS_ZERO32;
      enable_q <= `SIOS_ZERO32;
    end else if (wr) begin
      if (hit_c) ctrl_q <= apb_req.pwdata;
      if (hit_o) outcfg_q <= apb_req.pwdata;
      if (hit_i) incfg_q <= apb_req.pwdata;
      if (hit_p) pulse_q <= apb_req.pwdata;
      if (hit_e) enable_q <= apb_req.pwdata;
    end
  end
  wire loaded  = ctrl_q[`SIOS_CTRL_LOADED];
  wire moving  = ctrl_q[`SIOS_CTRL_MOVING];
  wire reduced = ctrl_q[`SIOS_CTRL_REDUCED];
  wire estop   = ctrl_q[`SIOS_CTRL_ESTOP];
  wire sfunc   = ctrl_q[`SIOS_CTRL_SFUNC];
  wire hwfault = ctrl_q[`SIOS_CTRL_HWFAULT];
  wire tst_clr = wr & hit_c & apb_req.pwdata[`SIOS_CTRL_TSTCLR];

  // =====================================================
  // input synchronisers and decode
  logic [NUM_IO-1:0] sa1_q, sa2_q, sb1_q, sb2_q, lvl_q, armed_q, fault_q, stop_q;
  logic [NUM_IO-1:0] cat1_w, cat2_w, ein_w;
  logic [CW-1:0]     hi_cnt_q [NUM_IO];
  logic [CW-1:0]     tst_cnt_q;
  logic              tst_on;
  logic [NUM_IO-1:0] tst_evt;

  function automatic sios_incfg_type in_mode(input logic [31:0] cfg, input int i);
    return sios_incfg_type'(cfg[2*i +: 2]);
  endfunction : in_mode

  // internal periodic test window, no outside request needed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tst_cnt_q <= '0;
    end else if (tst_cnt_q >= CW'(TEST_CYC - 1)) begin // R9
      tst_cnt_q <= '0;
    end else begin
      tst_cnt_q <= tst_cnt_q + 1'b1;
    end
  end
  assign tst_on = tst_cnt_q < CW'(PULSE_CYC); // R9
  // synchroniser lag: the pull-down still shows for two cycles after the window
  wire tst_blank = tst_cnt_q < CW'(PULSE_CYC + 2); // R9

  genvar g;
  generate
    for (g = 0; g < NUM_IO; g++) begin : g_in
      wire cfg_stop = in_mode(incfg_q, g) == SIOS_IN_CAT1 || in_mode(incfg_q, g) == SIOS_IN_CAT2;
      wire cfg_any  = in_mode(incfg_q, g) != SIOS_IN_OFF;
      wire level    = sa2_q[g] & sb2_q[g];
      // a pin that stays high while the test drive pulls it low is stuck
      wire stuck    = tst_on & cfg_any & (sa2_q[g] | sb2_q[g]) & (tst_cnt_q == CW'(PULSE_CYC - 1));
      wire mism     = ~tst_blank & cfg_any & (sa2_q[g] ^ sb2_q[g]);
      assign tst_evt[g] = stuck | mism;
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          sa1_q[g] <= 1'b1;
          sa2_q[g] <= 1'b1;
          sb1_q[g] <= 1'b1;
          sb2_q[g] <= 1'b1;
        end else begin
          sa1_q[g] <= safe_in[g].a;
          sa2_q[g] <= sa1_q[g];
          sb1_q[g] <= safe_in[g].b;
          sb2_q[g] <= sb1_q[g];
        end
      end
      // first actuation after restart must be a long high; shorter ones later
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          hi_cnt_q[g] <= '0;
          armed_q[g]  <= 1'b0;
          lvl_q[g]    <= 1'b0;
          fault_q[g]  <= 1'b0;
        end else begin
          if (!tst_blank) lvl_q[g] <= level;
          if (!tst_blank && level && hi_cnt_q[g] < CW'(FIRST_CYC)) hi_cnt_q[g] <= hi_cnt_q[g] + 1'b1;
          else if (!tst_blank && !level) hi_cnt_q[g] <= '0;
          if (hi_cnt_q[g] >= CW'(FIRST_CYC - 1) && level) armed_q[g] <= 1'b1; // R10 R11
          if (tst_evt[g]) fault_q[g] <= 1'b1;
          else if (tst_clr) fault_q[g] <= 1'b0;
        end
      end
      chk_fault_set: assert property (@(posedge clock) disable iff (rst)
        tst_evt[g] |=> fault_q[g]) else $error("test fault lost"); // R9
      // low means stop; unconfigured or unarmed inputs are ignored, faults stop
      assign stop_q[g] = cfg_any & ((armed_q[g] & ~lvl_q[g]) | fault_q[g]); // R14 R11
      assign cat1_w[g] = stop_q[g] & cfg_stop & in_mode(incfg_q, g) == SIOS_IN_CAT1;
      assign cat2_w[g] = stop_q[g] & cfg_stop & in_mode(incfg_q, g) == SIOS_IN_CAT2;
      assign ein_w[g]  = stop_q[g] & in_mode(incfg_q, g) == SIOS_IN_ESTOP;
    end
  endgenerate
  assign test_drive_n = {NUM_IO{~tst_on}};

  // =====================================================
  // output function selection
  logic [NUM_IO-1:0] out_q, act_w;
  generate
    for (g = 0; g < NUM_IO; g++) begin : g_out
      wire [1:0] cats   = pulse_q[8 + 2*g +: 2];
      wire       c1sel  = cats == 2'h0 | cats[0];
      wire       c2sel  = cats == 2'h0 | cats[1];
      wire       sstop  = (c1sel & |cat1_w) | (c2sel & |cat2_w) | |ein_w | sfunc | hwfault; // R4 R5
      wire       pulse  = pulse_q[g] & tst_on & out_q[g];
      always_comb begin
        unique case (sios_func_type'(outcfg_q[2*g +: 2])) // R1
          SIOS_FN_ESTOP:   act_w[g] = ~estop; // R3
          SIOS_FN_SSTOP:   act_w[g] = ~sstop; // R6
          SIOS_FN_MOVE:    act_w[g] = ~moving; // R7
          SIOS_FN_REDUCED: act_w[g] = reduced; // R8
        endcase
      end
      always_ff @(posedge clock or posedge rst) begin
        if (rst) out_q[g] <= 1'b0;
        else out_q[g] <= loaded & act_w[g]; // R15
      end
      // optional low test pulse; receiver must catch stuck-high and shorts
      assign safe_out[g].a = out_q[g] & ~pulse; // R2 R13
      assign safe_out[g].b = out_q[g] & ~pulse; // R2 R13
      chk_pair_equal: assert property (@(posedge clock) disable iff (rst)
        safe_out[g].a == safe_out[g].b) else $error("output pair differs"); // R2
      chk_unloaded_low: assert property (@(posedge clock) disable iff (rst)
        !loaded |=> !out_q[g]) else $error("output high before load"); // R15
      chk_estop_low: assert property (@(posedge clock) disable iff (rst)
        loaded && outcfg_q[2*g +: 2] == 2'h0 && estop |=> !out_q[g]) else $error("estop out high"); // R3
      chk_move_low: assert property (@(posedge clock) disable iff (rst)
        loaded && outcfg_q[2*g +: 2] == 2'h2 |=> out_q[g] == !$past(moving)) else $error("move out wrong"); // R7
      chk_mode_high: assert property (@(posedge clock) disable iff (rst)
        loaded && outcfg_q[2*g +: 2] == 2'h3 |=> out_q[g] == $past(reduced)) else $error("mode out wrong"); // R8
      chk_fault_stop: assert property (@(posedge clock) disable iff (rst)
        loaded && outcfg_q[2*g +: 2] == 2'h1 && hwfault |=> !out_q[g]) else $error("sstop out high"); // R4 R6
    end
  endgenerate

  // =====================================================
  // status and interrupt
  wire [31:0] evt_w  = {{(32-2*NUM_IO-1){1'b0}}, |cat1_w | |cat2_w, ein_w, tst_evt};
  wire [31:0] clr_w  = (wr & hit_k) ? apb_req.pwdata : `SIOS_ZERO32;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) status_q <= `SIOS_ZERO32;
    else status_q <= evt_w | (status_q & ~clr_w); // set wins over clear
  end
  assign irq     = |(status_q & enable_q);
  assign state_w = {{(32-3*NUM_IO){1'b0}}, armed_q, fault_q, out_q};

  sequence s_test_start;
    tst_cnt_q == '0;
  endsequence
  chk_test_period: assert property (@(posedge clock) disable iff (rst)
    s_test_start |-> tst_on ##1 tst_cnt_q == 32'h0000_0001) else $error("self test stalled"); // R9
  chk_test_range: assert property (@(posedge clock) disable iff (rst)
    tst_cnt_q < CW'(TEST_CYC)) else $error("self test counter out of range"); // R9
  chk_irq_level: assert property (@(posedge clock) disable iff (rst)
    (status_q & enable_q) != '0 |-> irq) else $error("irq missing");
endmodule : sios_top
`default_nettype wire

// [verification/sios_dev.sv]
// external safety device model that drives the redundant safety input pairs
`default_nettype none
module sios_dev (
  input  wire logic [3:0]         level,
  input  wire logic [3:0]         stuck,
  input  wire logic [3:0]         test_drive_n,
  output var sios_pkg::sios_pair_type safe_in [4]
);
  timeunit 1ns;
  timeprecision 1ps;
  import sios_pkg::*;
  // ==========
  // contact levels at the pins
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      // a healthy contact yields to the test pull-down, a stuck one does not
      safe_in[g].a = level[g] & (test_drive_n[g] | stuck[g]);
      safe_in[g].b = level[g] & (test_drive_n[g] | stuck[g]);
    end
  end
endmodule : sios_dev
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench for the safety io signalling block
`include "sios_regs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sios_pkg::*;
  localparam int TEST_CYC = 200;
  logic             clock = 1'b0;
  logic             rst = 1'b1;
  sios_apb_req_type apb_req = '0;
  logic [31:0]      prdata, rd, oc, c;
  logic             pready, pslverr, irq, err, seen;
  logic [3:0]       test_drive_n;
  logic [3:0]       level = 4'hF;
  logic [3:0]       stuck = 4'h0;
  sios_pair_type    safe_in [4];
  sios_pair_type    safe_out [4];
  int               miscompares = 0;
  int               checks_done = 0;
  int               cycles = 0;
  int               n;
  // ==========
  // clock, instances, timeout
  initial begin
    forever #12.5 clock = ~clock;
  end
  sios_top #(.FIRST_CYC(50), .SHORT_CYC(25), .TEST_CYC(TEST_CYC), .PULSE_CYC(4)) i_sios_top (
    .clock(clock), .rst(rst), .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .safe_in(safe_in), .safe_out(safe_out), .test_drive_n(test_drive_n), .irq(irq));
  sios_dev i_sios_dev (.level(level), .stuck(stuck), .test_drive_n(test_drive_n), .safe_in(safe_in));
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  // ==========
  // shared tasks
  task print_verdict;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task chk_out(input int g, input logic e);
    chk({30'h0, safe_out[g].a, safe_out[g].b}, {30'h0, e, e});
  endtask : chk_out
  // zero-wait slave, but the master still waits on pready
  task apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge clock);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: data};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    apb_req <= '0;
  endtask : apb
  task settle(input int k);
    repeat (k) @(posedge clock);
    @(negedge clock);
  endtask : settle
  function automatic logic exp_out(logic [1:0] fn, logic [31:0] v);
    case (sios_func_type'(fn))
      SIOS_FN_ESTOP: return v[0] & ~v[3];
      SIOS_FN_SSTOP: return v[0] & ~(v[4] | v[5]);
      SIOS_FN_MOVE:  return v[0] & ~v[1];
      default:       return v[0] & v[2];
    endcase
  endfunction : exp_out
  // ==========
  // main sequence
  initial begin
    void'($urandom(32'he709));
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    settle(0);
    for (int g = 0; g < 4; g++) chk_out(g, 1'b0);
    $display("reset state test done");
    // inputs held high from restart: the long first actuation
    for (int i = 0; i < 60; i++) begin
      oc = $urandom & 32'hFF;
      c = $urandom & 32'h3F;
      apb(1'b1, `SIOS_OFF_OUTCFG, oc);
      apb(1'b1, `SIOS_OFF_CTRL, c);
      settle(2);
      for (int g = 0; g < 4; g++)
        if (!(oc[2*g+:2] == 2'h1 && c[3])) chk_out(g, exp_out(oc[2*g+:2], c));
    end
    $display("function mix test done");
    apb(1'b1, `SIOS_OFF_OUTCFG, 32'h0000_00E4);
    apb(1'b1, `SIOS_OFF_CTRL, 32'h0000_0001);
    for (int ic = 0; ic < 4; ic++) begin
      for (int sel = 0; sel < 3; sel++) begin
        apb(1'b1, `SIOS_OFF_INCFG, ic);
        apb(1'b1, `SIOS_OFF_PULSE, sel << 10);
        @(posedge clock) level[0] <= 1'b0;
        settle(12);
        chk_out(1, !(ic == 3 || (ic != 0 && (sel == 0 || sel == ic))));
        @(posedge clock) level[0] <= 1'b1;
        settle(12);
        chk_out(1, 1'b1);
      end
    end
    apb(1'b0, `SIOS_OFF_STATUS, 32'h0);
    chk(rd & 32'h0000_0100, 32'h0000_0100);
    apb(1'b1, `SIOS_OFF_ENABLE, 32'h0000_0100);
    settle(1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `SIOS_OFF_ENABLE, 32'h0);
    settle(1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `SIOS_OFF_ENABLE, 32'h0000_0100);
    apb(1'b1, `SIOS_OFF_CLEAR, 32'h0000_0100);
    settle(1);
    chk({31'h0, irq}, 32'h0);
    $display("stop category and interrupt test done");
    apb(1'b1, `SIOS_OFF_PULSE, 32'h0000_0001);
    seen = 1'b0;
    repeat (TEST_CYC + 10) begin
      @(negedge clock);
      if (safe_out[0].a === 1'b0) seen = 1'b1;
    end
    chk({31'h0, seen}, 32'h1);
    n = 0;
    while (test_drive_n[0] !== 1'b0 && n < 2 * TEST_CYC) begin
      @(posedge clock);
      n++;
    end
    chk({31'h0, test_drive_n[0]}, 32'h0);
    apb(1'b1, `SIOS_OFF_INCFG, 32'h0000_0001);
    @(posedge clock) stuck <= 4'h1;
    settle(2 * TEST_CYC + 10);
    apb(1'b0, `SIOS_OFF_STATUS, 32'h0);
    chk(rd & 32'h0000_0001, 32'h0000_0001);
    chk_out(1, 1'b0);
    apb(1'b0, `SIOS_OFF_STATE, 32'h0);
    chk(rd & 32'h0000_0110, 32'h0000_0110);
    // release the stuck contact, then clear the fault with the test clear bit
    @(posedge clock) stuck <= 4'h0;
    settle(2 * TEST_CYC);
    apb(1'b1, `SIOS_OFF_CTRL, 32'h0000_0041);
    settle(3);
    chk_out(1, 1'b1);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("self-test and unmapped test done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
